// ===== led_boost_pkg.sv
/*
 Constants for the three-channel LED boost selection block: register map,
 field positions, reset values and current-level codes.
 Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package led_boost_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;

   // Control register fields
   localparam int CTRL_OVERRIDE_BIT = 0;
   localparam int CTRL_BOOST_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;

   // Status register fields
   localparam int STAT_STROBE_LSB = 0;
   localparam int STAT_BOOST_BIT = 3;
   localparam int STAT_SWITCH_BIT = 4;
   localparam int STAT_GATE_LSB = 8;
   localparam int STAT_LEVEL_LSB = 16;

   // Channel order in every 3-bit vector: 0 red, 1 green, 2 blue
   localparam int NUM_CH = 3;

   // Current-level codes towards the external converter stage
   localparam logic [1:0] LEVEL_ZERO = 2'h0;
   localparam logic [1:0] LEVEL_BOOST = 2'h1;
   localparam logic [1:0] LEVEL_FULL = 2'h2;

   // AHB constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

endpackage

// ===== led_boost_select.sv
/*
 Three-channel boost selection logic with an AHB-Lite register slave.
 Per channel it drives a registered two-bit current level and a registered
 fast LED gate from the colour strobes and the boost enable.
 Assumes strobes and the boost switch arrive asynchronously from pins and
 that the display controller raises one strobe at a time.
*/
// Summary of operation
// - Each fast gate output high turns its LED on and low turns it off.
// - A channel whose strobe is high selects the full current level.
// - A channel whose strobe is low takes the level chosen by the boost enable.
// - With boost off and the strobe low the level is zero.
// - With boost on and the strobe low the level is the fixed boost level.
// - With boost on a channel level only ever takes the full or the boost code.
// - Red, green and blue each apply the same level selection to their own strobe.
// - With boost on the green gate is high whenever any strobe is high.
// - With boost off the green gate follows the green strobe.
// - Red and blue gates follow the same rule as green with their own strobe.
// - With boost off the gate itself shuts the LED off outside its strobe.
`timescale 1ns/1ps
module led_boost_select (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] color_strobe,
   input wire logic boost_enable_switch,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic [5:0] current_level_select,
   output logic [2:0] fast_led_gate
);

   logic [2:0] strobe_meta_ff;
   logic [2:0] strobe_ff;
   logic switch_meta_ff;
   logic switch_ff;
   logic [1:0] ctrl_ff;
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic [31:0] rdata_ff;
   logic [5:0] level_ff;
   logic [2:0] gate_ff;
   logic boost_on;
   logic any_strobe;
   logic [5:0] nxt_level;
   logic [2:0] nxt_gate;
   logic addr_phase;
   logic [31:0] nxt_rdata;
   logic [31:0] status_word;

   function automatic logic [1:0] level_of(input logic strobe, input logic boost);
      if (strobe) begin
         level_of = led_boost_pkg::LEVEL_FULL;
      end else if (boost) begin
         level_of = led_boost_pkg::LEVEL_BOOST;
      end else begin
         level_of = led_boost_pkg::LEVEL_ZERO;
      end
   endfunction

   // Pin synchronisers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_meta_ff <= 3'h0;
         strobe_ff <= 3'h0;
         switch_meta_ff <= 1'h0;
         switch_ff <= 1'h0;
      end else begin
         strobe_meta_ff <= color_strobe;
         strobe_ff <= strobe_meta_ff;
         switch_meta_ff <= boost_enable_switch;
         switch_ff <= switch_meta_ff;
      end
   end

   // Software may override the switch pin
   assign boost_on = ctrl_ff[led_boost_pkg::CTRL_OVERRIDE_BIT] ?
                     ctrl_ff[led_boost_pkg::CTRL_BOOST_BIT] : switch_ff;
   assign any_strobe = |strobe_ff;

   genvar ch;
   generate
      for (ch = 0; ch < led_boost_pkg::NUM_CH; ch++) begin : g_ch
         assign nxt_level[2*ch +: 2] = level_of(strobe_ff[ch], boost_on);
         assign nxt_gate[ch] = boost_on ? any_strobe : strobe_ff[ch];
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_ff <= {3{led_boost_pkg::LEVEL_ZERO}};
         gate_ff <= 3'h0;
      end else begin
         level_ff <= nxt_level;
         gate_ff <= nxt_gate;
      end
   end

   assign current_level_select = level_ff;
   assign fast_led_gate = gate_ff;

   // AHB-Lite slave, zero wait states, always OKAY
   assign addr_phase = hsel && hready && (htrans == led_boost_pkg::HTRANS_NONSEQ);
   assign status_word = (32'(strobe_ff) << led_boost_pkg::STAT_STROBE_LSB) |
                        (32'(boost_on) << led_boost_pkg::STAT_BOOST_BIT) |
                        (32'(switch_ff) << led_boost_pkg::STAT_SWITCH_BIT) |
                        (32'(gate_ff) << led_boost_pkg::STAT_GATE_LSB) |
                        (32'(level_ff) << led_boost_pkg::STAT_LEVEL_LSB);
   assign nxt_rdata = (haddr[7:0] == led_boost_pkg::CTRL_OFS) ? {30'h0, ctrl_ff} :
                      (haddr[7:0] == led_boost_pkg::STATUS_OFS) ? status_word : 32'h0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_ff <= 1'h0;
         wr_addr_ff <= 8'h0;
         rdata_ff <= 32'h0;
      end else begin
         wr_pend_ff <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr_ff <= haddr[7:0];
         end
         if (addr_phase && !hwrite) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= led_boost_pkg::CTRL_RST;
      end else if (wr_pend_ff && wr_addr_ff == led_boost_pkg::CTRL_OFS) begin
         ctrl_ff <= hwdata[1:0];
      end
   end

   assign hreadyout = 1'h1;
   assign hresp = led_boost_pkg::HRESP_OKAY;
   assign hrdata = rdata_ff;

   // Checks
   property p_gate_on_off;
      @(posedge clk) disable iff (!rst_n)
         fast_led_gate[1] |-> ($past(boost_on) || $past(strobe_ff[1]));
   endproperty
   a_gate_on_off: assert property (p_gate_on_off) else $error("gate on without cause");

   property p_full_on_strobe;
      @(posedge clk) disable iff (!rst_n)
         strobe_ff[0] |=> current_level_select[1:0] == led_boost_pkg::LEVEL_FULL;
   endproperty
   a_full_on_strobe: assert property (p_full_on_strobe) else $error("red not full");

   property p_low_follows_boost;
      @(posedge clk) disable iff (!rst_n)
         !strobe_ff[2] |=> current_level_select[5:4] ==
            ($past(boost_on) ? led_boost_pkg::LEVEL_BOOST : led_boost_pkg::LEVEL_ZERO);
   endproperty
   a_low_follows_boost: assert property (p_low_follows_boost) else $error("blue low level");

   property p_zero_no_boost;
      @(posedge clk) disable iff (!rst_n)
         (!boost_on && !strobe_ff[1]) ##1 (!boost_on && !strobe_ff[1])
            |=> current_level_select[3:2] == led_boost_pkg::LEVEL_ZERO;
   endproperty
   a_zero_no_boost: assert property (p_zero_no_boost) else $error("green not zero");

   property p_boost_level;
      @(posedge clk) disable iff (!rst_n)
         (boost_on && !strobe_ff[0]) |=> current_level_select[1:0] == led_boost_pkg::LEVEL_BOOST;
   endproperty
   a_boost_level: assert property (p_boost_level) else $error("red not boost");

   property p_two_values;
      @(posedge clk) disable iff (!rst_n)
         $past(boost_on) |-> current_level_select[3:2] != led_boost_pkg::LEVEL_ZERO;
   endproperty
   a_two_values: assert property (p_two_values) else $error("green zero under boost");

   property p_green_or;
      @(posedge clk) disable iff (!rst_n)
         (boost_on && any_strobe) |=> fast_led_gate[1];
   endproperty
   a_green_or: assert property (p_green_or) else $error("green gate low under boost");

   property p_green_follow;
      @(posedge clk) disable iff (!rst_n)
         !boost_on |=> fast_led_gate[1] == $past(strobe_ff[1]);
   endproperty
   a_green_follow: assert property (p_green_follow) else $error("green gate mismatch");

   property p_blue_gate;
      @(posedge clk) disable iff (!rst_n)
         1'b1 |=> fast_led_gate[2] == ($past(boost_on) ? $past(any_strobe) : $past(strobe_ff[2]));
   endproperty
   a_blue_gate: assert property (p_blue_gate) else $error("blue gate mismatch");

   property p_off_outside;
      @(posedge clk) disable iff (!rst_n)
         (!boost_on && !strobe_ff[0])[*2] |-> !fast_led_gate[0];
   endproperty
   a_off_outside: assert property (p_off_outside) else $error("red gate on outside");

   property p_code_legal;
      @(posedge clk) disable iff (!rst_n)
         current_level_select[5:4] != 2'h3 ##1 current_level_select[1:0] != 2'h3;
   endproperty
   a_code_legal: assert property (p_code_legal) else $error("illegal level code");

   property p_full_g;
      @(posedge clk) disable iff (!rst_n)
         strobe_ff[1] |=> current_level_select[3:2] == led_boost_pkg::LEVEL_FULL;
   endproperty
   a_full_g: assert property (p_full_g) else $error("green not full");

   property p_full_b;
      @(posedge clk) disable iff (!rst_n)
         strobe_ff[2] |=> current_level_select[5:4] == led_boost_pkg::LEVEL_FULL;
   endproperty
   a_full_b: assert property (p_full_b) else $error("blue not full");

   property p_low_r;
      @(posedge clk) disable iff (!rst_n)
         !strobe_ff[0] |=> current_level_select[1:0] ==
            ($past(boost_on) ? led_boost_pkg::LEVEL_BOOST : led_boost_pkg::LEVEL_ZERO);
   endproperty
   a_low_r: assert property (p_low_r) else $error("red low level");

   property p_low_g;
      @(posedge clk) disable iff (!rst_n)
         !strobe_ff[1] |=> current_level_select[3:2] ==
            ($past(boost_on) ? led_boost_pkg::LEVEL_BOOST : led_boost_pkg::LEVEL_ZERO);
   endproperty
   a_low_g: assert property (p_low_g) else $error("green low level");

   property p_zero_r;
      @(posedge clk) disable iff (!rst_n)
         (!boost_on && !strobe_ff[0]) |=> current_level_select[1:0] == led_boost_pkg::LEVEL_ZERO;
   endproperty
   a_zero_r: assert property (p_zero_r) else $error("red not zero");

   property p_zero_b;
      @(posedge clk) disable iff (!rst_n)
         (!boost_on && !strobe_ff[2]) |=> current_level_select[5:4] == led_boost_pkg::LEVEL_ZERO;
   endproperty
   a_zero_b: assert property (p_zero_b) else $error("blue not zero");

   property p_boost_g;
      @(posedge clk) disable iff (!rst_n)
         (boost_on && !strobe_ff[1]) |=> current_level_select[3:2] == led_boost_pkg::LEVEL_BOOST;
   endproperty
   a_boost_g: assert property (p_boost_g) else $error("green not boost");

   property p_boost_b;
      @(posedge clk) disable iff (!rst_n)
         (boost_on && !strobe_ff[2]) |=> current_level_select[5:4] == led_boost_pkg::LEVEL_BOOST;
   endproperty
   a_boost_b: assert property (p_boost_b) else $error("blue not boost");

   property p_two_r;
      @(posedge clk) disable iff (!rst_n)
         $past(boost_on) |-> current_level_select[1:0] != led_boost_pkg::LEVEL_ZERO;
   endproperty
   a_two_r: assert property (p_two_r) else $error("red zero under boost");

   property p_two_b;
      @(posedge clk) disable iff (!rst_n)
         $past(boost_on) |-> current_level_select[5:4] != led_boost_pkg::LEVEL_ZERO;
   endproperty
   a_two_b: assert property (p_two_b) else $error("blue zero under boost");

   property p_same_ch;
      @(posedge clk) disable iff (!rst_n)
         (strobe_ff == 3'h0) |=> current_level_select == {3{current_level_select[1:0]}};
   endproperty
   a_same_ch: assert property (p_same_ch) else $error("channels differ in gap");

   property p_own_g;
      @(posedge clk) disable iff (!rst_n)
         (strobe_ff == 3'h1) |=> current_level_select[3:2] != led_boost_pkg::LEVEL_FULL;
   endproperty
   a_own_g: assert property (p_own_g) else $error("green full on red strobe");

   property p_red_or;
      @(posedge clk) disable iff (!rst_n)
         (boost_on && any_strobe) |=> fast_led_gate[0];
   endproperty
   a_red_or: assert property (p_red_or) else $error("red gate low under boost");

   property p_blue_or;
      @(posedge clk) disable iff (!rst_n)
         (boost_on && any_strobe) |=> fast_led_gate[2];
   endproperty
   a_blue_or: assert property (p_blue_or) else $error("blue gate low under boost");

   property p_red_follow;
      @(posedge clk) disable iff (!rst_n)
         !boost_on |=> fast_led_gate[0] == $past(strobe_ff[0]);
   endproperty
   a_red_follow: assert property (p_red_follow) else $error("red gate mismatch");

   property p_idle_off;
      @(posedge clk) disable iff (!rst_n)
         !any_strobe |=> fast_led_gate == 3'h0;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("gate on with no strobe");

   property p_code_g;
      @(posedge clk) disable iff (!rst_n)
         current_level_select[3:2] != 2'h3;
   endproperty
   a_code_g: assert property (p_code_g) else $error("illegal green code");

   property p_gate_cause_r;
      @(posedge clk) disable iff (!rst_n)
         fast_led_gate[0] |-> $past(any_strobe);
   endproperty
   a_gate_cause_r: assert property (p_gate_cause_r) else $error("red gate on without cause");

   property p_gate_cause_b;
      @(posedge clk) disable iff (!rst_n)
         fast_led_gate[2] |-> $past(any_strobe);
   endproperty
   a_gate_cause_b: assert property (p_gate_cause_b) else $error("blue gate on without cause");

   c_boost_cycle: cover property (@(posedge clk) disable iff (!rst_n)
      boost_on && strobe_ff[0] ##[1:20] boost_on && strobe_ff[1]);
   c_normal_cycle: cover property (@(posedge clk) disable iff (!rst_n)
      !boost_on && strobe_ff[2] ##1 !strobe_ff[2]);
   c_ctrl_write: cover property (@(posedge clk) disable iff (!rst_n)
      wr_pend_ff && wr_addr_ff == led_boost_pkg::CTRL_OFS);
   c_gap_boost: cover property (@(posedge clk) disable iff (!rst_n)
      boost_on && !any_strobe ##1 current_level_select == {3{led_boost_pkg::LEVEL_BOOST}});
   c_override: cover property (@(posedge clk) disable iff (!rst_n)
      ctrl_ff[led_boost_pkg::CTRL_OVERRIDE_BIT] &&
      (ctrl_ff[led_boost_pkg::CTRL_BOOST_BIT] != switch_ff));

endmodule

// ===== led_strobe_source.sv
/*
 Display controller model: raises one colour strobe at a time.
 Assumes the bench picks the colour index after a rising edge.
*/
`timescale 1ns/1ps
module led_strobe_source (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] color_idx,
   output logic [2:0] color_strobe
);
   logic [2:0] nxt_strobe;
   logic [2:0] strobe_ff;
   // Index 3 is a gap between colour times
   assign nxt_strobe = (color_idx == 2'h3) ? 3'h0 : 3'h1 << color_idx;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_ff <= 3'h0;
      end else begin
         strobe_ff <= nxt_strobe;
      end
   end
   assign color_strobe = strobe_ff;
endmodule

// ===== test_rgb_led_boost_select_logic.sv
/*
 Self-checking bench for the LED boost selection block.
 Assumes a zero-wait AHB-Lite slave and the strobe source model.
*/
`timescale 1ns/1ps
module test_rgb_led_boost_select_logic;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] color_idx = 2'h3;
   logic sw = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] rnd = 32'he8a6f492;
   logic [31:0] rd;
   logic [2:0] color_strobe, gate;
   logic hreadyout, hresp;
   logic [31:0] hrdata;
   logic [5:0] level;
   int n_mismatch = 0;
   int n_tests = 0;
   always #12.5 clk = ~clk;
   led_strobe_source i_src (.clk(clk), .rst_n(rst_n), .color_idx(color_idx),
      .color_strobe(color_strobe));
   led_boost_select i_dut (.clk(clk), .rst_n(rst_n), .color_strobe(color_strobe),
      .boost_enable_switch(sw), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .current_level_select(level), .fast_led_gate(gate));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [2:0] oh(input logic [1:0] i);
      return (i == 2'h3) ? 3'h0 : 3'h1 << i;
   endfunction
   function automatic logic [5:0] exp_lvl(input logic [2:0] s, input logic b);
      logic [5:0] e;
      for (int i = 0; i < 3; i++) begin
         e[2*i +: 2] = s[i] ? led_boost_pkg::LEVEL_FULL
            : (b ? led_boost_pkg::LEVEL_BOOST : led_boost_pkg::LEVEL_ZERO);
      end
      return e;
   endfunction
   function automatic logic [2:0] exp_gate(input logic [2:0] s, input logic b);
      return b ? {3{|s}} : s;
   endfunction
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= led_boost_pkg::HTRANS_NONSEQ;
      hsize <= 3'h2;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic step(input logic [1:0] idx, input logic s, input logic [1:0] c);
      logic b;
      logic [13:0] e_st;
      ahb(1'b1, 32'h0, {30'h0, c});
      @(posedge clk);
      color_idx <= idx;
      sw <= s;
      repeat (6) @(posedge clk);
      b = c[0] ? c[1] : s;
      chk(exp_lvl(oh(idx), b), level);
      chk(exp_gate(oh(idx), b), gate);
      e_st = {exp_lvl(oh(idx), b), exp_gate(oh(idx), b), s, b, oh(idx)};
      ahb(1'b0, 32'h4, 32'h0);
      chk(e_st, {rd[21:16], rd[10:8], rd[4:0]});
   endtask
   task automatic wrap_up;
      $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (19) @(posedge clk);
      chk(32'h0, {level, gate});
      @(posedge clk);
      rst_n <= 1'b1;
      ahb(1'b0, 32'h0, 32'h0);
      chk(32'h0, rd);
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 4; i++) step(2'(i), 1'(s), 2'(c));
         end
      end
      $display("test directed done");
      for (int k = 0; k < 40; k++) begin
         rnd = lfsr(rnd);
         step(rnd[1:0], rnd[2], rnd[4:3]);
      end
      $display("test random done");
      ahb(1'b1, 32'h0, 32'h2);
      ahb(1'b1, 32'h40, 32'hffffffff);
      ahb(1'b0, 32'h40, 32'h0);
      chk(32'h0, rd);
      ahb(1'b1, 32'h4, 32'hffffffff);
      ahb(1'b0, 32'h0, 32'h0);
      chk(32'h2, rd);
      chk({31'h0, led_boost_pkg::HRESP_OKAY}, {31'h0, hresp});
      chk(32'h1, {31'h0, hreadyout});
      step(2'h1, 1'b1, 2'h0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'h0, {level, gate});
      rst_n <= 1'b1;
      step(2'h2, 1'b0, 2'h3);
      $display("test bus and reset done");
      wrap_up();
   end
endmodule
